// *** hw/boundary_scan_test_port.sv ***
// boundary scan test port: access port controller, instruction decode, data registers, pin muxing
`timescale 1ns/1ps
`include "bscan_consts.svh"

// How it works
// - three-bit instruction register, shifted in LSB first
// - decoded instruction picks test and data register
// - code 000 puts boundary chain on serial path
// - external test captures inputs, shifts them out
// - external test drives outputs from updated patterns
// - code 100 chains boundary cells, keeps functional path
// - sample captures all pin values, shifts them out
// - code 110 puts identification register on path
// - code 111 delays serial data one test clock
// - identification: bit0 one, producer, part, revision
// - identification bits leave least significant first
// - skip register is a single bit
// - boundary chain is 98 cells long
// - even cells drive line ports, odd cells capture
// - cell 16 sets line port direction
module boundary_scan_test_port #(
    parameter logic [10:0] PRODUCER = `ID_PRODUCER, // arbitrary value
    parameter logic [15:0] PART = `ID_PART, // arbitrary value
    parameter logic [3:0] REVISION = `ID_REVISION // arbitrary value
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    input wire bscan_pkg::lane_t core_lp_out_i,
    input wire logic core_lp_dir_i,
    input wire bscan_pkg::misc_t misc_core_i,
    input wire bscan_pkg::lane_t lp_in_i,
    output bscan_pkg::lane_t lp_out_o,
    output bscan_pkg::lane_t lp_oe_n_o,
    input wire bscan_pkg::misc_t misc_pin_i,
    output bscan_pkg::misc_t misc_pin_o
);
    import bscan_pkg::*;

    localparam logic [`ID_WIDTH-1:0] ID_CODE = {REVISION, PART, PRODUCER, `ID_FIXED_BIT};

    tck_rise_s r;
    tck_rise_s next_r;
    tck_fall_s f;
    tck_fall_s next_f;
    core_s c;
    core_s next_c;
    logic bsr_sel;
    logic id_sel;
    logic skip_sel;
    chain_t cap;
    lane_t hold_lp;

    chain_if chain();

    scan_chain_cells u_cells (
        .bus(chain.cells)
    );

    // next state of the access port controller
    function automatic tap_state_e tap_next(input tap_state_e s, input logic tms);
        tap_state_e n;
        n = s;
        unique case (s)
            TLR: n = tms ? TLR : RTI;
            RTI: n = tms ? SEL_DR : RTI;
            SEL_DR: n = tms ? SEL_IR : CAP_DR;
            CAP_DR: n = tms ? EX1_DR : SH_DR;
            SH_DR: n = tms ? EX1_DR : SH_DR;
            EX1_DR: n = tms ? UPD_DR : PAUSE_DR;
            PAUSE_DR: n = tms ? EX2_DR : PAUSE_DR;
            EX2_DR: n = tms ? UPD_DR : SH_DR;
            UPD_DR: n = tms ? SEL_DR : RTI;
            SEL_IR: n = tms ? TLR : CAP_IR;
            CAP_IR: n = tms ? EX1_IR : SH_IR;
            SH_IR: n = tms ? EX1_IR : SH_IR;
            EX1_IR: n = tms ? UPD_IR : PAUSE_IR;
            PAUSE_IR: n = tms ? EX2_IR : PAUSE_IR;
            EX2_IR: n = tms ? UPD_IR : SH_IR;
            UPD_IR: n = tms ? SEL_DR : RTI;
        endcase
        return n;
    endfunction

    // instruction decode; anything unlisted falls to the skip bit
    assign bsr_sel = (f.ir == `INSN_EXTEST) || (f.ir == `INSN_SAMPLE);
    assign id_sel = (f.ir == `INSN_IDCODE);
    assign skip_sel = !bsr_sel && !id_sel;

    // capture image: line port pairs, direction cell, remaining pins
    generate
        for (genvar i = 0; i < `LINE_PORTS; i++) begin : g_line
            assign cap[2*i] = r.lpout2[i];
            assign cap[2*i+1] = r.lpin2[i];
            assign hold_lp[i] = c.hold[2*i];
        end
    endgenerate
    assign cap[`DIR_CELL] = r.dir2;
    assign cap[`CHAIN_BITS-1:`DIR_CELL+1] = r.misc2;

    // chain cell controls, all on the test clock
    assign chain.tck = tck_i;
    assign chain.tdi = tdi_i;
    assign chain.capture = (r.state == CAP_DR) && bsr_sel;
    assign chain.shift = (r.state == SH_DR) && bsr_sel;
    assign chain.update = (r.state == UPD_DR) && bsr_sel;
    assign chain.clear = r.rst2 || (r.state == TLR);
    assign chain.capture_data = cap;

    // rising test clock: controller, instruction and data shifters, pin sync
    always_comb begin
        next_r = r;
        next_r.rst1 = reset_i;
        next_r.rst2 = r.rst1;
        next_r.state = r.rst2 ? TLR : tap_next(r.state, tms_i);
        if (r.state == CAP_IR) begin
            next_r.ir_sh = `IR_CAPTURE;
        end
        if (r.state == SH_IR) begin
            next_r.ir_sh = {tdi_i, r.ir_sh[`IR_WIDTH-1:1]};
        end
        if (r.state == CAP_DR) begin
            next_r.skip = 1'b0;
            if (id_sel) begin
                next_r.id_sh = ID_CODE;
            end
        end
        if (r.state == SH_DR) begin
            next_r.skip = tdi_i;
            if (id_sel) begin
                next_r.id_sh = {tdi_i, r.id_sh[`ID_WIDTH-1:1]};
            end
        end
        // pins and core-driven levels come from other clocks
        next_r.lpin1 = lp_in_i;
        next_r.lpin2 = r.lpin1;
        next_r.lpout1 = lp_out_o;
        next_r.lpout2 = r.lpout1;
        next_r.dir1 = lp_oe_n_o[0];
        next_r.dir2 = r.dir1;
        next_r.misc1 = misc_pin_i;
        next_r.misc2 = r.misc1;
    end

    always_ff @(posedge tck_i) begin
        r <= next_r;
    end

    // falling test clock: serial output, instruction update, update toggle
    always_comb begin
        next_f = f;
        next_f.tdo_oe_n = !((r.state == SH_DR) || (r.state == SH_IR));
        if (r.state == SH_IR) begin
            next_f.tdo = r.ir_sh[0];
        end else if (r.state == SH_DR) begin
            if (bsr_sel) begin
                next_f.tdo = chain.serial_out;
            end else if (id_sel) begin
                next_f.tdo = r.id_sh[0];
            end else begin
                next_f.tdo = r.skip;
            end
        end
        if (r.state == UPD_IR) begin
            next_f.ir = r.ir_sh;
        end
        if (chain.update) begin
            next_f.upd_tog = !f.upd_tog;
        end
        if (r.rst2 || (r.state == TLR)) begin
            next_f.ir = `INSN_IDCODE;
        end
        next_f.ext = (next_f.ir == `INSN_EXTEST);
        if (r.rst2) begin
            next_f.tdo = 1'b0;
            next_f.tdo_oe_n = 1'b1;
            next_f.upd_tog = 1'b0;
        end
    end

    always_ff @(negedge tck_i) begin
        f <= next_f;
    end

    // core clock: the update stage only moves at an update or a clear, and stays put for at least
    // a few test clocks after it, so copying it three core cycles after the toggle is safe
    always_comb begin
        next_c = c;
        next_c.ext1 = f.ext;
        next_c.ext2 = c.ext1;
        next_c.tog1 = f.upd_tog;
        next_c.tog2 = c.tog1;
        next_c.tog3 = c.tog2;
        if (c.tog2 != c.tog3) begin
            next_c.hold = chain.update_data;
        end
        if (c.ext2) begin
            next_c.lp_out = hold_lp;
            next_c.lp_oe_n = {`LINE_PORTS{c.hold[`DIR_CELL]}};
            next_c.misc_out = c.hold[`CHAIN_BITS-1:`DIR_CELL+1];
        end else begin
            next_c.lp_out = core_lp_out_i;
            next_c.lp_oe_n = {`LINE_PORTS{core_lp_dir_i}};
            next_c.misc_out = misc_core_i;
        end
        if (reset_i) begin
            next_c = '0;
            next_c.hold = `CHAIN_RESET;
            next_c.lp_oe_n = '1;
        end
    end

    always_ff @(posedge clock_i) begin
        c <= next_c;
    end

    assign tdo_o = f.tdo;
    assign tdo_oe_n_o = f.tdo_oe_n;
    assign lp_out_o = c.lp_out;
    assign lp_oe_n_o = c.lp_oe_n;
    assign misc_pin_o = c.misc_out;

    // three instruction shifts in a row
    sequence s_ir_three_shifts;
        (r.state == SH_IR) [*3];
    endsequence

    // a data capture with the given register selected, then a shift
    sequence s_cap_then_shift(sel);
        (r.state == CAP_DR && sel) ##1 (r.state == SH_DR);
    endsequence

    a_ir_lsb_first: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        s_ir_three_shifts |=> r.ir_sh == {$past(tdi_i, 1), $past(tdi_i, 2), $past(tdi_i, 3)})
    else $error("instruction bits not shifted in lsb first");

    a_ir_update_edge: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        (r.state == UPD_IR) |=> (f.ir == $past(r.ir_sh)))
    else $error("instruction not taken at update");

    a_tap_five_ones: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        tms_i [*5] |=> (r.state == TLR))
    else $error("five mode-select ones did not reach reset state");

    a_bypass_one_delay: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        (r.state == SH_DR && $past(r.state) == SH_DR && skip_sel && $past(skip_sel))
        |-> (tdo_o == $past(tdi_i) && !tdo_oe_n_o))
    else $error("bypass data not delayed by one test clock");

    a_unlisted_bypass: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        s_cap_then_shift(f.ir == 3'h2) |-> (tdo_o == 1'b0))
    else $error("unlisted code did not select skip bit");

    a_idcode_first_bit: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        s_cap_then_shift(id_sel) |-> (tdo_o == `ID_FIXED_BIT))
    else $error("identification code did not start with fixed one");

    a_chain_first_cell: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        s_cap_then_shift(bsr_sel) |-> (tdo_o == $past(cap[0])))
    else $error("boundary chain did not present captured cell 0");

    a_extest_drives_pins: assert property (
        @(posedge clock_i) disable iff (reset_i)
        ((c.tog2 != c.tog3) && c.ext2) |-> ##2 (!$past(c.ext2) || lp_out_o == $past(hold_lp)))
    else $error("updated pattern not driven on line ports");

    a_preload_keeps_core: assert property (
        @(posedge clock_i) disable iff (reset_i)
        !c.ext2 |=> (lp_out_o == $past(core_lp_out_i) && misc_pin_o == $past(misc_core_i)))
    else $error("functional path broken outside external test");

    a_dir_cell_hiz: assert property (
        @(posedge clock_i) disable iff (reset_i)
        (c.ext2 && c.hold[`DIR_CELL]) |=> (lp_oe_n_o == 8'hff))
    else $error("direction cell one did not release line ports");

    // serial output only drives while a register is shifting, never when idle
    a_tdo_shift_only: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        (r.state == SH_DR || r.state == SH_IR || r.state == RTI) |-> (tdo_oe_n_o == (r.state == RTI)))
    else $error("serial output enable wrong for controller state");

    a_reset_picks_idcode: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        (r.state == TLR) |=> (f.ir == `INSN_IDCODE))
    else $error("reset state did not select identification");

    a_skip_capture_zero: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        (r.state == CAP_DR) |=> !r.skip)
    else $error("skip bit not cleared at capture");

    a_id_fields: assert property (
        @(posedge tck_i) disable iff (r.rst2)
        (r.state == CAP_DR && id_sel) |=> (r.id_sh == {REVISION, PART, PRODUCER, 1'b1}))
    else $error("identification fields not loaded at capture");
endmodule

// *** hw/scan_chain_cells.sv ***
// boundary chain: capture/shift stage and falling-edge update stage
`timescale 1ns/1ps
`include "bscan_consts.svh"

module scan_chain_cells (
    chain_if.cells bus
);
    import bscan_pkg::*;

    chain_t sh;
    chain_t next_sh;
    chain_t upd;
    chain_t next_upd;

    // cell 0 sits next to the serial output, so it leaves first
    always_comb begin
        next_sh = sh;
        if (bus.capture) begin
            next_sh = bus.capture_data;
        end else if (bus.shift) begin
            next_sh = {bus.tdi, sh[`CHAIN_BITS-1:1]};
        end
    end

    always_ff @(posedge bus.tck) begin
        sh <= next_sh;
    end

    // update stage holds still while shifting so pins never ripple
    always_comb begin
        next_upd = upd;
        if (bus.clear) begin
            next_upd = `CHAIN_RESET;
        end else if (bus.update) begin
            next_upd = sh;
        end
    end

    always_ff @(negedge bus.tck) begin
        upd <= next_upd;
    end

    assign bus.serial_out = sh[0];
    assign bus.update_data = upd;
endmodule

// *** inc/bscan_consts.svh ***
// shared constants of the boundary scan test port
`ifndef BSCAN_CONSTS_SVH
`define BSCAN_CONSTS_SVH

// instruction register
`define IR_WIDTH 3
`define IR_CAPTURE 3'h1
`define INSN_EXTEST 3'h0
`define INSN_SAMPLE 3'h4
`define INSN_IDCODE 3'h6
`define INSN_BYPASS 3'h7

// identification register layout, field values are arbitrary
`define ID_WIDTH 32
`define ID_FIXED_BIT 1'h1
`define ID_PRODUCER_LSB 1
`define ID_PART_LSB 12
`define ID_REVISION_LSB 28
`define ID_PRODUCER 11'h2a5
`define ID_PART 16'h0c3e
`define ID_REVISION 4'h1

// boundary chain layout
`define CHAIN_BITS 98
`define LINE_PORTS 8
`define DIR_CELL 16
`define MISC_BITS 81
`define CHAIN_RESET 98'h0_0000_0000_0000_0000_0001_0000

`endif

// *** inc/bscan_pkg.sv ***
// types of the boundary scan test port
`include "bscan_consts.svh"

package bscan_pkg;

    typedef logic [`LINE_PORTS-1:0] lane_t;
    typedef logic [`MISC_BITS-1:0] misc_t;
    typedef logic [`CHAIN_BITS-1:0] chain_t;
    typedef logic [`IR_WIDTH-1:0] insn_t;

    // standard sixteen-state access port sequence
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAUSE_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAUSE_IR, EX2_IR, UPD_IR
    } tap_state_e;

    // state clocked on the rising test clock edge
    typedef struct packed {
        tap_state_e state;
        logic rst1;
        logic rst2;
        insn_t ir_sh;
        logic skip;
        logic [`ID_WIDTH-1:0] id_sh;
        lane_t lpin1;
        lane_t lpin2;
        lane_t lpout1;
        lane_t lpout2;
        logic dir1;
        logic dir2;
        misc_t misc1;
        misc_t misc2;
    } tck_rise_s;

    // state clocked on the falling test clock edge
    typedef struct packed {
        insn_t ir;
        logic tdo;
        logic tdo_oe_n;
        logic upd_tog;
        logic ext;
    } tck_fall_s;

    // state clocked by the core clock
    typedef struct packed {
        logic ext1;
        logic ext2;
        logic tog1;
        logic tog2;
        logic tog3;
        chain_t hold;
        lane_t lp_out;
        lane_t lp_oe_n;
        misc_t misc_out;
    } core_s;

endpackage

// *** inc/chain_if.sv ***
// link between the access port controller and the boundary chain cells
`timescale 1ns/1ps
`include "bscan_consts.svh"

interface chain_if;
    import bscan_pkg::*;
    logic tck;
    logic capture;
    logic shift;
    logic update;
    logic clear;
    logic tdi;
    chain_t capture_data;
    logic serial_out;
    chain_t update_data;

    modport ctrl (
        output tck, capture, shift, update, clear, tdi, capture_data,
        input serial_out, update_data
    );
    modport cells (
        input tck, capture, shift, update, clear, tdi, capture_data,
        output serial_out, update_data
    );
endinterface

// *** testbench/tap_host_model.sv ***
// model of the outside board test controller that steers the access port
`timescale 1ns/1ps

module tap_host_model (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_n_i
);
    logic spare;

    // test clock stands low between steps, serial input starts low
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        spare = 1'b0;
    end

    // one 48 ns test clock period; tdo read just before the rising edge, half a period after it moved
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #24;
        tdo = tdo_oe_n_i ? 1'bx : tdo_i; // a released tdo is never trusted
        tck_o = 1'b1;
        #24;
        tck_o = 1'b0;
    endtask

    // state move; tdi toggles so that nothing relies on a stale level
    task automatic move(input logic tms);
        logic t;
        step(tms, spare, t);
        spare = ~spare;
    endtask

    // full scan from run-test/idle back to run-test/idle, bit 0 first on both lines
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic t;
        dout = '0;
        move(1'b1);
        if (ir) begin
            move(1'b1);
        end
        move(1'b0);
        move(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], t);
            dout[i] = t;
        end
        move(1'b1);
        move(1'b0);
    endtask
endmodule

// *** testbench/tb_boundary_scan_test_port.sv ***
// self-checking bench for the boundary scan test port
`timescale 1ns/1ps
`include "bscan_consts.svh"

module tb_boundary_scan_test_port;
    import bscan_pkg::*;
    localparam logic [31:0] ID_EXP = {`ID_REVISION, `ID_PART, `ID_PRODUCER, `ID_FIXED_BIT};
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe_n;
    lane_t core_lp_out = 8'h00;
    lane_t lp_ext = 8'hc9;
    lane_t lp_wire, lp_out, lp_oe_n;
    logic core_lp_dir = 1'b1;
    misc_t misc_core = '0;
    misc_t misc_pin = {9{9'h1a3}};
    misc_t misc_out;
    int bad_count = 0;
    int n_checks = 0;
    logic [127:0] got;

    // core clock, 5 ns period
    always #2.5 clock_i = ~clock_i;

    // line port wire: the device wins while it drives, else the board level shows
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lp_wire[i] = lp_oe_n[i] ? lp_ext[i] : lp_out[i];
        end
    end

    boundary_scan_test_port i_dut (
        .clock_i(clock_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .core_lp_out_i(core_lp_out), .core_lp_dir_i(core_lp_dir),
        .misc_core_i(misc_core), .lp_in_i(lp_wire), .lp_out_o(lp_out), .lp_oe_n_o(lp_oe_n),
        .misc_pin_i(misc_pin), .misc_pin_o(misc_out)
    );

    tap_host_model i_host (
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n)
    );

    // compare and count
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // chain image: even cells drive, odd cells sense, then direction, then the other pins
    function automatic chain_t pins(lane_t drv, logic dir, lane_t sns, misc_t m);
        chain_t c;
        for (int i = 0; i < `LINE_PORTS; i++) begin
            c[2*i] = drv[i];
            c[2*i+1] = sns[i];
        end
        c[`DIR_CELL] = dir;
        c[97:17] = m;
        return c;
    endfunction

    task automatic load_ir(input insn_t code);
        i_host.scan(1'b1, 3, {125'h0, code}, got);
        check("ir capture", got[2:0], 3'h1);
    endtask

    task automatic wait_core(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic t_idcode();
        i_host.scan(1'b0, 32, 128'h0, got);
        check("idcode after reset", got[31:0], ID_EXP);
        check("tdo released when idle", tdo_oe_n, 1'b1);
    endtask

    // codes 1 to 7 except 4: identification for code 6, a one-bit skip path for the others
    task automatic t_codes();
        logic [31:0] din;
        din = 32'h9e37_79b9;
        for (int c = 1; c < 8; c++) begin
            if (c != 4) begin
                load_ir(insn_t'(c));
                i_host.scan(1'b0, 32, {96'h0, din}, got);
                check("data path", got[31:0], (c == 6) ? ID_EXP : {din[30:0], 1'b0});
            end
        end
    endtask

    // sample keeps the functional path; 100 bits prove the chain is 98 long
    task automatic t_sample();
        chain_t pre;
        pre = pins(8'h5a, 1'b0, 8'h00, ~misc_pin);
        wait_core(1);
        core_lp_out = 8'ha5;
        core_lp_dir = 1'b0;
        misc_core = {27{3'h6}};
        wait_core(10);
        check("functional drive", lp_out, 8'ha5);
        load_ir(`INSN_SAMPLE);
        i_host.scan(1'b0, 100, {28'h0, pre, 2'b10}, got);
        check("sample capture", got[97:0], pins(8'ha5, 1'b0, 8'ha5, misc_pin));
        check("chain length", got[99:98], 2'b10);
        wait_core(10);
        check("functional drive kept", {lp_out, lp_oe_n, misc_out}, {8'ha5, 8'h00, misc_core});
    endtask

    // one external-test scan; only sensed cells are judged, drive cells depend on earlier updates
    task automatic extest_scan(input lane_t sns, input misc_t drv);
        chain_t m;
        m = pins(8'h00, 1'b0, 8'hff, {81{1'b1}});
        i_host.scan(1'b0, 98, {30'h0, pins(8'h00, 1'b1, 8'h00, drv)}, got);
        check("extest capture", got[97:0] & m, pins(8'h00, 1'b0, sns, misc_pin) & m);
    endtask

    task automatic t_extest();
        load_ir(`INSN_EXTEST);
        wait_core(1);
        core_lp_out = 8'hff;
        wait_core(10);
        check("preload on pins", {lp_out, lp_oe_n, misc_out}, {8'h5a, 8'h00, ~misc_pin});
        misc_pin = {27{3'h3}};
        extest_scan(8'h5a, {27{3'h5}});
        wait_core(10);
        check("pins released", lp_oe_n, 8'hff);
        check("update on pins", misc_out, {27{3'h5}});
        extest_scan(8'hc9, {27{3'h5}});
        repeat (5) i_host.move(1'b1);
        i_host.move(1'b0);
        wait_core(10);
        check("core path back", lp_out, 8'hff);
    endtask

    // test clock runs during reset so that the port's synchroniser sees it
    initial begin
        repeat (5) i_host.move(1'b1);
        @(negedge clock_i);
        check("reset drive enable", {lp_out, lp_oe_n}, {8'h00, 8'hff});
        reset_i = 1'b0;
        repeat (3) i_host.move(1'b1);
        i_host.move(1'b0);
        t_idcode();
        t_codes();
        t_sample();
        t_extest();
        stop_test();
    end

    // watchdog, several times the expected run of about 32 us
    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
endmodule
